//--- hw/lcd_host_port_front_end.sv
// Host port front end: mode strap decode, chip select, parallel strobes,
// serial pin roles and a byte-valid pulse toward the command/data core.
// Assumes all host pins are synchronous to clk_in or slow against it.
// Operation
// - Selected accepts transfers; deselected floats data bus, except in I2C.
// - Deselected ignores select and strobe levels.
// - Serial clear output raised when deselected in SPI modes.
// - Three straps decode five interface modes.
// - Top low, middle high enables parallel port.
// - Select high means data, low means command.
// - 6800 read/write pin high reads, low writes.
// - 8080 captures byte on write strobe rise.
// - 6800 write captures on enable falling edge.
// - 6800 read drives bus while enable high.
// - 8080 read drives bus while read strobe low.
// - Reads return data or status; writes store data.
// - Serial modes map clock, data in, out bits.
// - I2C maps clock, data, out, address straps.
// - Parallel write with select low is instruction.
`timescale 1ns/1ns
`default_nettype none
module lcd_host_port_front_end (
    // Clock and reset.
    input  wire logic                            clk_in,
    input  wire logic                            reset_in,
    // Interface mode straps, top strap in bit 2.
    input  wire logic [2:0]                      mode_straps_in,
    // Host control pins.
    input  wire logic                            chip_select_n_in,
    input  wire logic                            data_command_select_in,
    input  wire logic                            write_control_pin_in,
    input  wire logic                            read_control_pin_in,
    // Data bus pins as three signals.
    input  wire logic [7:0]                      bus_in,
    output var  logic [7:0]                      bus_out,
    output var  logic [7:0]                      bus_oe_out,
    // Core side: read sources.
    input  wire logic [7:0]                      read_data_in,
    input  wire logic [7:0]                      status_in,
    input  wire logic                            serial_dout_in,
    input  wire logic                            serial_dout_en_in,
    // Core side: written byte and data read-end pulse.
    output var  host_port_pkg::host_byte_type    byte_out,
    output var  logic                            byte_valid_out,
    output var  logic                            data_read_out,
    // Serial engines side.
    output var  host_port_pkg::if_mode_type      mode_out,
    output var  host_port_pkg::serial_pins_type  serial_pins_out,
    output var  logic                            serial_clear_out
);

    // =========================================================================
    // Mode decode.
    // =========================================================================
    // The straps are decoded continuously; unlisted codes leave the port dead.
    host_port_pkg::if_mode_type mode_d;
    host_port_pkg::if_mode_type mode_q;
    always_comb begin
        case (mode_straps_in)
            host_port_pkg::STRAP_PAR_8080: mode_d = host_port_pkg::MODE_8080;
            host_port_pkg::STRAP_PAR_6800: mode_d = host_port_pkg::MODE_6800;
            host_port_pkg::STRAP_SER_4L:   mode_d = host_port_pkg::MODE_SPI4;
            host_port_pkg::STRAP_SER_3L:   mode_d = host_port_pkg::MODE_SPI3;
            host_port_pkg::STRAP_I2C:      mode_d = host_port_pkg::MODE_I2C;
            default:                       mode_d = host_port_pkg::MODE_NONE;
        endcase
    end

    // Registered mode so every decision uses a clean, settled value.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            mode_q <= host_port_pkg::MODE_NONE;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Parallel port is alive only when top strap low and middle strap high.
    wire is_par   = (mode_q == host_port_pkg::MODE_8080) ||
                    (mode_q == host_port_pkg::MODE_6800);
    wire is_8080  = (mode_q == host_port_pkg::MODE_8080);
    wire is_6800  = (mode_q == host_port_pkg::MODE_6800);
    wire is_spi   = (mode_q == host_port_pkg::MODE_SPI4) ||
                    (mode_q == host_port_pkg::MODE_SPI3);
    wire is_i2c   = (mode_q == host_port_pkg::MODE_I2C);
    // Chip select is ignored in I2C; the board ties it high there.
    wire selected = ~chip_select_n_in & ~is_i2c;

    // =========================================================================
    // Strobe synchronisers and edge detection.
    // =========================================================================
    // Two flops per strobe; the third stage is only for edge detection so the
    // first stage is never looked at by logic.
    logic [1:0] wr_sync_q;
    logic [1:0] rd_sync_q;
    logic       wr_prev_q;
    logic       rd_prev_q;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            wr_sync_q <= 2'h3;
            rd_sync_q <= 2'h3;
            wr_prev_q <= 1'h1;
            rd_prev_q <= 1'h1;
        end else begin
            wr_sync_q <= {wr_sync_q[0], write_control_pin_in};
            rd_sync_q <= {rd_sync_q[0], read_control_pin_in};
            wr_prev_q <= wr_sync_q[1];
            rd_prev_q <= rd_sync_q[1];
        end
    end

    wire wr_s     = wr_sync_q[1];
    wire rd_s     = rd_sync_q[1];
    wire wr_rise  = wr_s & ~wr_prev_q;
    wire rd_fall  = ~rd_s & rd_prev_q;
    // 8080 write: rising edge of the low-active write strobe.
    wire wr_8080  = is_8080 & selected & wr_rise;
    // 6800: write pin low means write, captured on enable falling edge.
    wire wr_6800  = is_6800 & selected & ~wr_s & rd_fall;
    // Deselected cycles never create a transfer.
    wire par_wr   = is_par & (wr_8080 | wr_6800);

    // Read window per handshake style.
    wire rd_8080  = is_8080 & selected & ~read_control_pin_in;
    wire rd_6800  = is_6800 & selected & write_control_pin_in &
                    read_control_pin_in;
    wire par_rd   = rd_8080 | rd_6800;
    // End of a data read lets the core advance its pointer.
    wire rd_8080_end = is_8080 & selected & rd_s & ~rd_prev_q;
    wire rd_6800_end = is_6800 & selected & wr_s & rd_fall;
    wire rd_done  = (rd_8080_end | rd_6800_end) & data_command_select_in;

    // Byte pins and select held one cycle so the capture matches the edge
    // seen through the synchroniser; host hold time must cover two cycles.
    logic [7:0] bus_hold_q;
    logic       dc_hold_q;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            bus_hold_q <= host_port_pkg::BUS_RESET;
            dc_hold_q  <= 1'h1;
        end else begin
            bus_hold_q <= bus_in;
            dc_hold_q  <= data_command_select_in;
        end
    end

    // =========================================================================
    // Serial pin roles and clear.
    // =========================================================================
    // The serial engines own the protocol; here they get pins and a clear.
    // In 3-line and I2C the select pin is unused and the board ties it high.
    wire ser_clear = is_spi & chip_select_n_in;
    host_port_pkg::serial_pins_type pins_d;
    always_comb begin
        pins_d.sclk      = bus_in[host_port_pkg::SER_CLK_BIT];
        pins_d.sdin      = bus_in[host_port_pkg::SER_DIN_BIT];
        pins_d.slave_lsb = is_i2c ? bus_in[7:host_port_pkg::I2C_ADDR_LO] : 2'h0;
    end

    // =========================================================================
    // Bus drive.
    // =========================================================================
    // Read data is status when select low, display data when high.
    wire [7:0] rd_byte = data_command_select_in ? read_data_in : status_in;
    logic [7:0] oe_d;
    logic [7:0] out_d;
    always_comb begin
        oe_d  = 8'h00;
        out_d = 8'h00;
        if (par_rd) begin
            oe_d  = 8'hff;
            out_d = rd_byte;
        end else if (is_spi & selected & serial_dout_en_in) begin
            oe_d[host_port_pkg::SER_DOUT_HI:host_port_pkg::SER_DOUT_LO]  = 2'h3;
            out_d[host_port_pkg::SER_DOUT_HI:host_port_pkg::SER_DOUT_LO] = {2{serial_dout_in}};
        end else if (is_i2c & serial_dout_en_in) begin
            oe_d[host_port_pkg::I2C_DOUT_HI:host_port_pkg::SER_DOUT_LO]  = 4'hf;
            out_d[host_port_pkg::I2C_DOUT_HI:host_port_pkg::SER_DOUT_LO] = {4{serial_dout_in}};
        end
    end

    // =========================================================================
    // Output registers.
    // =========================================================================
    // All outputs come from flops; bus drive lags the strobe by one cycle.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            bus_out          <= host_port_pkg::BUS_RESET;
            bus_oe_out       <= 8'h00;
            byte_out         <= '0;
            byte_valid_out   <= 1'h0;
            data_read_out    <= 1'h0;
            mode_out         <= host_port_pkg::MODE_NONE;
            serial_pins_out  <= '0;
            serial_clear_out <= 1'h1;
        end else begin
            bus_out          <= out_d;
            bus_oe_out       <= selected | is_i2c ? oe_d : 8'h00;
            byte_valid_out   <= par_wr;
            if (par_wr) begin
                byte_out.value   <= bus_hold_q;
                byte_out.is_data <= dc_hold_q;
            end
            data_read_out    <= rd_done;
            mode_out         <= mode_q;
            serial_pins_out  <= pins_d;
            serial_clear_out <= ser_clear;
        end
    end

    // =========================================================================
    // Assertions.
    // =========================================================================
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    AST_DESELECT_FLOAT: assert property (chip_select_n_in & ~is_i2c |=> bus_oe_out == 8'h00)
        else $error("Bus driven while deselected.");
    AST_DESELECT_NO_BYTE: assert property (chip_select_n_in & ~is_i2c |=> ~byte_valid_out)
        else $error("Byte accepted while deselected.");
    AST_SERIAL_CLEAR: assert property (is_spi & chip_select_n_in |=> serial_clear_out)
        else $error("Serial logic not cleared while deselected.");
    AST_MODE_DECODE: assert property (mode_straps_in == host_port_pkg::STRAP_I2C
        ##1 mode_straps_in == host_port_pkg::STRAP_I2C |=> mode_out == host_port_pkg::MODE_I2C)
        else $error("Strap decode wrong.");
    AST_NO_PAR_OUTSIDE: assert property (~is_par |=> ~byte_valid_out)
        else $error("Parallel write outside parallel mode.");
    AST_KIND: assert property (par_wr |=> byte_out.is_data == $past(dc_hold_q))
        else $error("Data/command flag not captured.");
    AST_8080_WRITE: assert property (wr_8080 |=> byte_valid_out && byte_out.value == $past(bus_hold_q))
        else $error("8080 write not captured on strobe rise.");
    AST_6800_WRITE: assert property (wr_6800 |=> byte_valid_out)
        else $error("6800 write not captured on enable fall.");
    AST_6800_READ: assert property (rd_6800 |=> bus_oe_out == 8'hff)
        else $error("6800 read not driving bus.");
    AST_8080_READ: assert property (rd_8080 |=> bus_oe_out == 8'hff)
        else $error("8080 read not driving bus.");
    AST_STATUS_READ: assert property (par_rd & ~data_command_select_in |=> bus_out == $past(status_in))
        else $error("Status read returns wrong byte.");
    AST_PULSE: assert property (byte_valid_out |=> ~byte_valid_out)
        else $error("Byte-valid pulse longer than one cycle.");

    COV_8080_WRITE: cover property (wr_8080 ##1 byte_valid_out);
    COV_6800_WRITE: cover property (wr_6800 ##1 byte_valid_out);
    COV_STATUS_READ: cover property (rd_8080 & ~data_command_select_in);
    COV_I2C_OUT: cover property (is_i2c & serial_dout_en_in);

endmodule : lcd_host_port_front_end
`default_nettype wire

//--- hw/host_port_pkg.sv
// Shared types and constants for the display controller host port front end.
// Assumes a single 20 MHz clock domain and a synchronous active-high reset.
`default_nettype none
package host_port_pkg;

    // =========================================================================
    // Interface mode strap codes, top strap first.
    // =========================================================================
    localparam logic [2:0] STRAP_PAR_8080 = 3'h3; // L,H,H.
    localparam logic [2:0] STRAP_PAR_6800 = 3'h2; // L,H,L.
    localparam logic [2:0] STRAP_SER_4L   = 3'h1; // L,L,H.
    localparam logic [2:0] STRAP_SER_3L   = 3'h0; // L,L,L.
    localparam logic [2:0] STRAP_I2C      = 3'h6; // H,H,L.

    // Bus bit positions for the serial roles.
    localparam int SER_CLK_BIT  = 0;
    localparam int SER_DIN_BIT  = 1;
    localparam int SER_DOUT_LO  = 2;
    localparam int SER_DOUT_HI  = 3;
    localparam int I2C_DOUT_HI  = 5;
    localparam int I2C_ADDR_LO  = 6;

    // Reset values.
    localparam logic [7:0] BUS_RESET   = 8'h00;
    localparam logic [3:0] COUNT_RESET = 4'h0;

    // =========================================================================
    // Decoded interface mode, one-hot.
    // =========================================================================
    typedef enum logic [5:0] {
        MODE_NONE = 6'h01,
        MODE_8080 = 6'h02,
        MODE_6800 = 6'h04,
        MODE_SPI4 = 6'h08,
        MODE_SPI3 = 6'h10,
        MODE_I2C  = 6'h20
    } if_mode_type;

    // Byte handed to the core, with its kind.
    typedef struct packed {
        logic       is_data;   // High for display data, low for instruction.
        logic [7:0] value;     // The byte itself.
    } host_byte_type;

    // Serial pin roles presented to the serial engines.
    typedef struct packed {
        logic       sclk;      // Serial clock from the bus.
        logic       sdin;      // Serial data in.
        logic [1:0] slave_lsb; // Slave address straps, I2C only.
    } serial_pins_type;

endpackage : host_port_pkg
`default_nettype wire

//--- sim/host_mcu_model.sv
// Behavioural host microcontroller for the host port front end bench.
// Assumes the bench resolves the shared data bus from both enables.
`timescale 1ns/1ns
`default_nettype none
module host_mcu_model (
    // Clock used only to pace the pins.
    input  wire logic       clk_in,
    // Host pins toward the device.
    output var  logic       chip_select_n_out,
    output var  logic       dc_out,
    output var  logic       wr_out,
    output var  logic       rd_out,
    output var  logic [7:0] data_out,
    output var  logic       data_oe_out
);
    // =========================================================================
    // Idle levels: deselected, select high, strobes inactive.
    // =========================================================================
    initial begin
        chip_select_n_out = 1'b1;
        dc_out            = 1'b1;
        wr_out            = 1'b1;
        rd_out            = 1'b1;
        data_out          = 8'h00;
        data_oe_out       = 1'b0;
    end

    // Drive the pins for serial use; the select stays high as the board ties it.
    task drive(input logic cs_n, input logic [7:0] d);
        @(negedge clk_in);
        chip_select_n_out = cs_n;
        dc_out            = 1'b1;
        data_out          = d;
        data_oe_out       = 1'b1;
    endtask : drive

    // One parallel cycle; setup and recovery of three cycles keep the sync happy.
    task xfer(input bit m6800, input logic cs_n, input bit rd, input logic dc,
              input logic [7:0] d, input int hold);
        // Strobes settle to this mode's idle levels while still deselected, so an
        // enable that drops from the 8080 idle level is never taken as a write.
        @(negedge clk_in);
        wr_out            = m6800 ? rd : 1'b1;
        rd_out            = !m6800;
        repeat (3) @(negedge clk_in);
        chip_select_n_out = cs_n;
        dc_out            = dc;
        data_out          = d;
        data_oe_out       = !rd;
        repeat (3) @(negedge clk_in);
        if (m6800) begin
            rd_out = 1'b1;
        end else if (rd) begin
            rd_out = 1'b0;
        end else begin
            wr_out = 1'b0;
        end
        repeat (hold) @(negedge clk_in);
        rd_out = !m6800;
        wr_out = m6800 ? rd : 1'b1;
        repeat (3) @(negedge clk_in);
        chip_select_n_out = 1'b1;
        data_oe_out       = 1'b0;
        wr_out            = 1'b1;
    endtask : xfer
endmodule : host_mcu_model
`default_nettype wire

//--- sim/lcd_host_port_front_end_test.sv
// Self-checking bench for the host port front end.
// Assumes the host model above and the design package are compiled first.
`timescale 1ns/1ns
`default_nettype none
module lcd_host_port_front_end_test;
    logic clk_in = 1'b0;          // System clock, 50 ns period.
    logic reset_in = 1'b1;        // Synchronous reset.
    logic [2:0] straps = 3'h3;    // Mode straps.
    logic [7:0] rdata = 8'h96;    // Display data for reads.
    logic [7:0] stat = 8'h4b;     // Status byte for reads.
    logic sdo = 1'b1;             // Serial data out bit.
    logic sdo_en = 1'b0;          // Serial data out enable.
    wire logic cs_n, dc, wr, rd, h_oe;
    wire logic [7:0] h_d, bus, b_out, b_oe;
    host_port_pkg::host_byte_type byte_v;
    host_port_pkg::if_mode_type mode;
    host_port_pkg::serial_pins_type pins;
    logic valid, clr, dread;
    int num_errors = 0;           // Mismatches seen.
    int comparisons = 0;          // Checks made.

    // A released host line shows the inverse of its last value, never a hold.
    assign bus = (b_oe & b_out) | (~b_oe & (h_oe ? h_d : ~h_d));

    initial begin
        forever #25 clk_in = ~clk_in;
    end

    host_mcu_model host_u (.clk_in(clk_in), .chip_select_n_out(cs_n), .dc_out(dc),
        .wr_out(wr), .rd_out(rd), .data_out(h_d), .data_oe_out(h_oe));

    lcd_host_port_front_end dut_u (.clk_in(clk_in), .reset_in(reset_in),
        .mode_straps_in(straps), .chip_select_n_in(cs_n), .data_command_select_in(dc),
        .write_control_pin_in(wr), .read_control_pin_in(rd), .bus_in(bus),
        .bus_out(b_out), .bus_oe_out(b_oe), .read_data_in(rdata), .status_in(stat),
        .serial_dout_in(sdo), .serial_dout_en_in(sdo_en), .byte_out(byte_v),
        .byte_valid_out(valid), .data_read_out(dread), .mode_out(mode),
        .serial_pins_out(pins), .serial_clear_out(clr));

    // =========================================================================
    // Checking helpers.
    // =========================================================================
    task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
            num_errors++;
        end
    endtask : chk

    task set_mode(input logic [2:0] s);
        @(negedge clk_in);
        straps = s;
        repeat (3) @(negedge clk_in);
    endtask : set_mode

    // Write, then watch for exactly one single-cycle pulse, or none if refused.
    task write(input bit m68, input logic cs_n_v, input logic dc_v, input logic [7:0] d);
        int seen;
        seen = 0;
        fork
            host_u.xfer(m68, cs_n_v, 1'b0, dc_v, d, 3);
            repeat (14) begin
                @(posedge clk_in);
                #1;
                if (valid === 1'b1) begin
                    seen++;
                    chk(byte_v, {dc_v, d}, "written byte");
                end
            end
        join
        chk(seen[15:0], {15'h0, !cs_n_v}, "byte pulses");
    endtask : write

    // Read, checking the driven bus mid-strobe and its release afterwards.
    task read(input bit m68, input logic cs_n_v, input logic dc_v);
        fork
            host_u.xfer(m68, cs_n_v, 1'b1, dc_v, 8'h00, 6);
            begin
                repeat (9) @(posedge clk_in);
                #1;
                chk(b_oe, cs_n_v ? 8'h00 : 8'hff, "read enable");
                if (!cs_n_v) chk(b_out, dc_v ? rdata : stat, "read value");
            end
        join
        chk(b_oe, 8'h00, "bus released");
        chk(dread, !cs_n_v && dc_v, "read end pulse");
    endtask : read

    task conclude;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude

    // Strap code beside the mode it should decode to.
    logic [8:0] rows [8] = '{{3'h0, 6'h10}, {3'h1, 6'h08}, {3'h2, 6'h04}, {3'h3, 6'h02},
                             {3'h4, 6'h01}, {3'h5, 6'h01}, {3'h6, 6'h20}, {3'h7, 6'h01}};

    // =========================================================================
    // Main sequence.
    // =========================================================================
    initial begin
        repeat (5) @(negedge clk_in);
        chk({mode, clr, b_oe, valid}, {6'h01, 1'b1, 8'h00, 1'b0}, "reset values");
        reset_in = 1'b0;
        foreach (rows[i]) begin
            set_mode(rows[i][8:6]);
            chk(mode, rows[i][5:0], "mode decode");
        end
        set_mode(3'h3);
        write(1'b0, 1'b0, 1'b1, 8'ha5);
        write(1'b0, 1'b0, 1'b0, 8'h3c);
        write(1'b0, 1'b1, 1'b1, 8'h77);
        read(1'b0, 1'b0, 1'b0);
        read(1'b0, 1'b0, 1'b1);
        read(1'b0, 1'b1, 1'b0);
        set_mode(3'h2);
        write(1'b1, 1'b0, 1'b1, 8'h5a);
        write(1'b1, 1'b0, 1'b0, 8'hc3);
        read(1'b1, 1'b0, 1'b1);
        set_mode(3'h1);
        sdo_en = 1'b1;
        host_u.drive(1'b0, 8'hf2);
        repeat (3) @(negedge clk_in);
        chk({pins, clr, b_oe[7:4], b_oe[3:2]}, {4'h4, 1'b0, 4'h0, 2'h3}, "four-line pins");
        host_u.drive(1'b1, 8'hf2);
        repeat (3) @(negedge clk_in);
        chk({clr, b_oe}, {1'b1, 8'h00}, "serial clear");
        set_mode(3'h6);
        host_u.drive(1'b1, 8'hc1);
        repeat (3) @(negedge clk_in);
        chk({pins, b_oe[5:2]}, {4'hb, 4'hf}, "bus roles in two-wire mode");
        // A reset in mid-run returns the outputs to idle; the straps decode afresh.
        reset_in = 1'b1;
        repeat (2) @(negedge clk_in);
        chk({mode, clr, b_oe, valid}, {6'h01, 1'b1, 8'h00, 1'b0}, "mid-run reset");
        reset_in = 1'b0;
        repeat (3) @(negedge clk_in);
        chk(mode, 6'h20, "mode after reset");
        conclude();
    end

    // Cuts a hang short well past the few hundred cycles the tests need.
    initial begin
        repeat (5000) @(posedge clk_in);
        num_errors++;
        conclude();
    end
endmodule : lcd_host_port_front_end_test
`default_nettype wire
